// ==== standard_timer_module.sv ====
// Standard timer module: 10-bit counter, compare A and P, output pin modes
//
// Notes on behaviour
// - Counter readable as low byte and two-bit high byte, upper bits zero.
// - Compare-A value is a writable, readable 10-bit byte pair, reset zero.
// - Mode 00 compare output, 11 timer, 10 PWM or single pulse.
// - Clear-select low: clear on P match or overflow; both flags raised.
// - Clear-select high: clear on A match; only A flag raised.
// - Compare-A zero: counter overflows past 3FF, no A flag.
// - Compare mode pin changes on A match, per pin function, and on on-bit rise.
// - Rising edge of on bit returns pin to output-control level.
// - Timer mode counts like compare mode but leaves the pin undriven.
// - Swap bit picks which comparator clears and which sets duty.
// - Swap 0: period is period value times 128, or 1024; duty compare-A.
// - Swap 1: period is compare-A; duty period value times 128 or 1024.
// - Duty at or above period gives a constantly active output.
// - PWM raises a flag on every A match and every P match.
// - PWM keeps counting when pin forced; active level and polarity apply.
// - Single pulse: on-bit rise, by software or pin edge, starts pulse.
// - Single pulse ends on on-bit clear or A match, which raises A flag.
// - Single pulse counter clears only on on-bit rise; P unused.
// - On-bit rise zeroes counter; fall stops and holds it.
// - Pause bit holds counter; counting resumes from held value.
// - Period value compares with counter bits 9 to 7; bits 6 to 0 must be zero.
// - Compare pin action: none, low, high or toggle.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module standard_timer_module (
   input  wire logic                                     i_clk,
   input  wire logic                                     i_resetn,
   input  wire logic [standard_timer_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic [standard_timer_pkg::BYTE_W-1:0]    i_wdata,
   input  wire logic                                     i_wr,
   input  wire logic                                     i_rd,
   output logic      [standard_timer_pkg::BYTE_W-1:0]    o_rdata,
   input  wire logic                                     i_fh_tick,
   input  wire logic                                     i_fsub_tick,
   input  wire logic                                     i_external_count_pin,
   output logic                                          o_pin_out,
   output logic                                          o_pin_oe_n,
   output logic                                          o_compare_a_flag,
   output logic                                          o_compare_p_flag
);
   import standard_timer_pkg::*;

   timer_control_zero_s            ctrl0_r;
   timer_control_one_s             ctrl1_r;
   logic [CNT_W-1:0]               compare_a_value_r;
   logic [CNT_W-1:0]               count_r;
   logic [CNT_W-1:0]               count_nxt;
   logic                           on_prev_r;
   logic                           pin_ext_prev_r;
   logic [1:0]                     sys_div_r;
   logic [PRE_W-1:0]               h_div_r;
   logic                           flag_a_r;
   logic                           flag_p_r;
   logic                           pin_r;
   logic                           pin_nxt;
   logic                           oe_n_r;
   logic                           oe_n_nxt;
   logic [BYTE_W-1:0]              rdata_r;

   logic                           on_rise;
   logic                           pin_rise;
   logic                           pin_fall;
   logic                           pin_edge;
   logic                           sys4_tick;
   logic                           h16_tick;
   logic                           h64_tick;
   logic                           clk_event;
   logic                           tick;
   logic [CNT_W-1:0]               cnt_inc;
   logic                           a_hit;
   logic                           p_hit;
   logic                           overflow;
   logic                           is_compare;
   logic                           is_pwm;
   logic                           is_single;
   logic                           clr_count;
   logic                           set_a;
   logic                           set_p;
   logic [CNT_W:0]                 duty_len;
   logic [CNT_W:0]                 per_len;
   logic                           pwm_active;
   logic                           active_lvl;
   logic                           wave;

   // Mode decode
   assign is_compare = (ctrl1_r.op_mode == MODE_COMPARE) ||
                       (ctrl1_r.op_mode == MODE_TIMER) ||
                       (ctrl1_r.op_mode == MODE_CAPTURE);
   assign is_single  = (ctrl1_r.op_mode == MODE_PWM) &&
                       (ctrl1_r.pin_function == FN_TOGGLE);
   assign is_pwm     = (ctrl1_r.op_mode == MODE_PWM) && !is_single;

   // Timer clock sources
   assign sys4_tick = (sys_div_r[1:0] == 2'(DIV_SYS - 1));
   assign h16_tick  = i_fh_tick && (h_div_r[3:0] == 4'(DIV_H_LO - 1));
   assign h64_tick  = i_fh_tick && (h_div_r == PRE_W'(DIV_H_HI - 1));
   assign pin_rise  = i_external_count_pin && !pin_ext_prev_r;
   assign pin_fall  = !i_external_count_pin && pin_ext_prev_r;
   assign pin_edge  = (ctrl0_r.clk_sel == CK_PIN_FALL) ? pin_fall : pin_rise;

   always_comb begin
      case (ctrl0_r.clk_sel)
         CK_SYS_DIV4: clk_event = sys4_tick;
         CK_SYS:      clk_event = 1'b1;
         CK_H_DIV16:  clk_event = h16_tick;
         CK_H_DIV64:  clk_event = h64_tick;
         CK_SUB_A:    clk_event = i_fsub_tick;
         CK_SUB_B:    clk_event = i_fsub_tick;
         CK_PIN_RISE: clk_event = pin_rise;
         CK_PIN_FALL: clk_event = pin_fall;
         default:     clk_event = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sys_div_r <= '0;
      end else begin
         sys_div_r <= sys_div_r + 2'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         h_div_r <= '0;
      end else if (i_fh_tick) begin
         h_div_r <= h_div_r + PRE_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_ext_prev_r <= 1'b0;
         on_prev_r      <= 1'b0;
      end else begin
         pin_ext_prev_r <= i_external_count_pin;
         on_prev_r      <= ctrl0_r.module_on;
      end
   end

   assign on_rise = ctrl0_r.module_on && !on_prev_r;

   // Counting and comparators
   assign tick     = ctrl0_r.module_on && !on_rise &&
                     !ctrl0_r.count_pause && clk_event;
   assign cnt_inc  = count_r + CNT_W'(1);
   assign overflow = tick && (count_r == CNT_MAX);
   assign a_hit    = tick && (compare_a_value_r != RST_COUNT) &&
                     (cnt_inc == compare_a_value_r);
   assign p_hit    = tick && ((ctrl0_r.period_value == '0) ? overflow :
                     ((cnt_inc[CNT_W-1:CNT_W-PER_W] ==
                       ctrl0_r.period_value) &&
                      (cnt_inc[CNT_W-PER_W-1:0] == '0)));

   always_comb begin
      clr_count = 1'b0;
      set_a     = 1'b0;
      set_p     = 1'b0;
      if (is_compare) begin
         if (ctrl1_r.clear_select) begin
            clr_count = a_hit;
            set_a     = a_hit;
         end else begin
            clr_count = p_hit;
            set_a     = a_hit;
            set_p     = p_hit;
         end
      end else if (is_pwm) begin
         clr_count = ctrl1_r.duty_period_swap ? a_hit : p_hit;
         set_a     = a_hit;
         set_p     = p_hit;
      end else begin
         set_a     = a_hit;
      end
   end

   always_comb begin
      if (on_rise) begin
         count_nxt = RST_COUNT;
      end else if (!tick) begin
         count_nxt = count_r;
      end else if (clr_count) begin
         count_nxt = RST_COUNT;
      end else begin
         count_nxt = cnt_inc;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_r <= RST_COUNT;
      end else begin
         count_r <= count_nxt;
      end
   end

   // Flags: hardware set wins over software clear
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         flag_a_r <= 1'b0;
         flag_p_r <= 1'b0;
      end else begin
         if (set_a) begin
            flag_a_r <= 1'b1;
         end else if (i_wr && i_addr == OFS_FLAGS &&
                      i_wdata[FLAG_A_BIT]) begin
            flag_a_r <= 1'b0;
         end
         if (set_p) begin
            flag_p_r <= 1'b1;
         end else if (i_wr && i_addr == OFS_FLAGS &&
                      i_wdata[FLAG_P_BIT]) begin
            flag_p_r <= 1'b0;
         end
      end
   end

   // Control registers; pin edge start wins over a software write
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl0_r <= timer_control_zero_s'(RST_BYTE);
      end else begin
         if (i_wr && i_addr == OFS_CTRL_ZERO) begin
            ctrl0_r <= timer_control_zero_s'(i_wdata);
         end else if (is_single && a_hit) begin
            ctrl0_r.module_on <= 1'b0;
         end
         if (is_single && !ctrl0_r.module_on && pin_edge) begin
            ctrl0_r.module_on <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl1_r <= timer_control_one_s'(RST_BYTE);
      end else if (i_wr && i_addr == OFS_CTRL_ONE) begin
         ctrl1_r <= timer_control_one_s'(i_wdata);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         compare_a_value_r <= RST_COUNT;
      end else if (i_wr && i_addr == OFS_CMPA_LOW) begin
         compare_a_value_r[BYTE_W-1:0] <= i_wdata;
      end else if (i_wr && i_addr == OFS_CMPA_HIGH) begin
         compare_a_value_r[CNT_W-1:BYTE_W] <=
            i_wdata[CNT_W-BYTE_W-1:0];
      end
   end

   // PWM waveform
   always_comb begin
      if (ctrl1_r.duty_period_swap) begin
         per_len  = (compare_a_value_r == RST_COUNT) ? PER_FULL :
                    {1'b0, compare_a_value_r};
         duty_len = (ctrl0_r.period_value == '0) ? PER_FULL :
                    (CNT_W+1)'(ctrl0_r.period_value) * PER_STEP;
      end else begin
         per_len  = (ctrl0_r.period_value == '0) ? PER_FULL :
                    (CNT_W+1)'(ctrl0_r.period_value) * PER_STEP;
         duty_len = {1'b0, compare_a_value_r};
      end
   end

   assign pwm_active = (duty_len >= per_len) ||
                       ({1'b0, count_r} < duty_len);
   assign active_lvl = ctrl1_r.output_control;

   always_comb begin
      case (ctrl1_r.pin_function)
         FN_NONE: wave = !active_lvl;
         FN_LOW:  wave = active_lvl;
         FN_HIGH: wave = pwm_active ? active_lvl : !active_lvl;
         default: wave = ctrl0_r.module_on ? active_lvl :
                         !active_lvl;
      endcase
   end

   // Compare-mode pin state
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_r <= 1'b0;
      end else if (on_rise) begin
         pin_r <= ctrl1_r.output_control;
      end else if (ctrl1_r.op_mode == MODE_COMPARE && set_a) begin
         case (ctrl1_r.pin_function)
            FN_LOW:    pin_r <= 1'b0;
            FN_HIGH:   pin_r <= 1'b1;
            FN_TOGGLE: pin_r <= !pin_r;
            default:   pin_r <= pin_r;
         endcase
      end
   end

   always_comb begin
      pin_nxt  = 1'b0;
      oe_n_nxt = 1'b1;
      if (ctrl1_r.op_mode == MODE_COMPARE) begin
         pin_nxt  = pin_r ^ ctrl1_r.output_polarity;
         oe_n_nxt = 1'b0;
      end else if (ctrl1_r.op_mode == MODE_PWM) begin
         pin_nxt  = wave ^ ctrl1_r.output_polarity;
         oe_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pin_out <= 1'b0;
         oe_n_r    <= 1'b1;
      end else begin
         o_pin_out <= pin_nxt;
         oe_n_r    <= oe_n_nxt;
      end
   end

   assign o_pin_oe_n       = oe_n_r;
   assign o_compare_a_flag = flag_a_r;
   assign o_compare_p_flag = flag_p_r;

   // Read port: data valid only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= RST_BYTE;
      end else if (i_rd) begin
         case (i_addr)
            OFS_CTRL_ZERO: rdata_r <= BYTE_W'(ctrl0_r);
            OFS_CTRL_ONE:  rdata_r <= BYTE_W'(ctrl1_r);
            OFS_CNT_LOW:   rdata_r <= count_r[BYTE_W-1:0];
            OFS_CNT_HIGH:  rdata_r <= {6'h00,
                                       count_r[CNT_W-1:BYTE_W]};
            OFS_CMPA_LOW:  rdata_r <= compare_a_value_r[BYTE_W-1:0];
            OFS_CMPA_HIGH: rdata_r <= {6'h00,
                                       compare_a_value_r[CNT_W-1:BYTE_W]};
            OFS_FLAGS:     rdata_r <= {6'h00, flag_p_r, flag_a_r};
            default:       rdata_r <= RST_BYTE;
         endcase
      end else begin
         rdata_r <= RST_BYTE;
      end
   end

   assign o_rdata = rdata_r;

endmodule : standard_timer_module

`default_nettype wire

// ==== standard_timer_module_assertions.sv ====
// Port-level assertions for the standard timer module
`timescale 1ns/1ps
`default_nettype none

module standard_timer_assertions
   import standard_timer_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_resetn,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [BYTE_W-1:0] i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [BYTE_W-1:0] o_rdata,
   input wire logic              o_pin_oe_n,
   input wire logic              o_compare_a_flag,
   input wire logic              o_compare_p_flag
);
   logic [7:0] ctl1_r;
   logic [7:0] ctl1_old_r;
   logic [7:0] cmpa_lo_r;
   logic [1:0] cmpa_hi_r;
   logic       cmpa_zero_old_r;
   logic       clr_a;
   logic       clr_p;
   logic       cmpa_zero;

   assign clr_a = i_wr && i_addr == OFS_FLAGS && i_wdata[FLAG_A_BIT];
   assign clr_p = i_wr && i_addr == OFS_FLAGS && i_wdata[FLAG_P_BIT];
   assign cmpa_zero = cmpa_lo_r == 8'h00 && cmpa_hi_r == 2'h0;

   // Shadow of the configuration software wrote
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl1_r    <= 8'h00;
         cmpa_lo_r <= 8'h00;
         cmpa_hi_r <= 2'h0;
      end else if (i_wr) begin
         case (i_addr)
            OFS_CTRL_ONE:  ctl1_r    <= i_wdata;
            OFS_CMPA_LOW:  cmpa_lo_r <= i_wdata;
            OFS_CMPA_HIGH: cmpa_hi_r <= i_wdata[1:0];
            default:       ;
         endcase
      end
   end

   // Settings a cycle old, so the design has taken them
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl1_old_r      <= 8'h00;
         cmpa_zero_old_r <= 1'b1;
      end else begin
         ctl1_old_r      <= ctl1_r;
         cmpa_zero_old_r <= cmpa_zero;
      end
   end

   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   a_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_cnt_high_zero: assert property ($past(i_rd) &&
      $past(i_addr) == OFS_CNT_HIGH |-> o_rdata[7:2] == 6'h00)
      else $error("count high byte upper bits not zero");
   a_cmpa_low_back: assert property ($past(i_rd) &&
      $past(i_addr) == OFS_CMPA_LOW |-> o_rdata == $past(cmpa_lo_r))
      else $error("compare A low byte read back wrong");
   a_cmpa_high_back: assert property ($past(i_rd) &&
      $past(i_addr) == OFS_CMPA_HIGH |-> o_rdata == {6'h00, $past(cmpa_hi_r)})
      else $error("compare A high byte read back wrong");
   a_flag_a_sticky: assert property (o_compare_a_flag && !clr_a &&
      !$past(clr_a) |=> o_compare_a_flag)
      else $error("A flag dropped without a clear");
   a_flag_p_sticky: assert property (o_compare_p_flag && !clr_p &&
      !$past(clr_p) |=> o_compare_p_flag)
      else $error("P flag dropped without a clear");
   a_timer_undriven: assert property (ctl1_r[7:6] == 2'b11 &&
      ctl1_old_r[7:6] == 2'b11 |-> o_pin_oe_n)
      else $error("pin driven in timer mode");
   a_output_driven: assert property (!ctl1_r[6] && !ctl1_old_r[6] &&
      $past(i_resetn, 2) |-> !o_pin_oe_n)
      else $error("pin not driven in an output mode");
   a_no_p_flag: assert property (ctl1_r[7:6] == 2'b00 && ctl1_r[0] &&
      ctl1_old_r[7:6] == 2'b00 && ctl1_old_r[0] |-> !$rose(o_compare_p_flag))
      else $error("P flag raised with clear on A");
   a_no_a_flag: assert property (cmpa_zero && cmpa_zero_old_r &&
      ctl1_r[7:6] == 2'b00 && ctl1_old_r[7:6] == 2'b00
      |-> !$rose(o_compare_a_flag))
      else $error("A flag raised with compare A at zero");

endmodule : standard_timer_assertions

bind standard_timer_module standard_timer_assertions
   standard_timer_assertions_i (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_pin_oe_n(o_pin_oe_n), .o_compare_a_flag(o_compare_a_flag),
   .o_compare_p_flag(o_compare_p_flag)
);

`default_nettype wire

// ==== standard_timer_pkg.sv ====
// Constants, register map and field layouts of the standard timer module
package standard_timer_pkg;

   localparam int CNT_W    = 10;
   localparam int PER_W    = 3;
   localparam int BYTE_W   = 8;
   localparam int ADDR_W   = 3;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL_ZERO  = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_CTRL_ONE   = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_CNT_LOW    = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_CNT_HIGH   = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_CMPA_LOW   = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_CMPA_HIGH  = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_FLAGS      = 3'h6;

   // Field positions of the flag register
   localparam int FLAG_A_BIT = 0;
   localparam int FLAG_P_BIT = 1;

   // Reset values and counter maximum
   localparam logic [BYTE_W-1:0] RST_BYTE  = 8'h00;
   localparam logic [CNT_W-1:0]  RST_COUNT = 10'h000;
   localparam logic [CNT_W-1:0]  CNT_MAX   = 10'h3ff;

   // Prescaler divide ratios
   localparam int DIV_SYS  = 4;
   localparam int DIV_H_LO = 16;
   localparam int DIV_H_HI = 64;
   localparam int PRE_W    = 6;

   // Count weight of one period step, and full-range period
   localparam logic [CNT_W:0] PER_STEP = 11'h080;
   localparam logic [CNT_W:0] PER_FULL = 11'h400;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_CAPTURE = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } op_mode_e;

   typedef enum logic [2:0] {
      CK_SYS_DIV4  = 3'b000,
      CK_SYS       = 3'b001,
      CK_H_DIV16   = 3'b010,
      CK_H_DIV64   = 3'b011,
      CK_SUB_A     = 3'b100,
      CK_SUB_B     = 3'b101,
      CK_PIN_RISE  = 3'b110,
      CK_PIN_FALL  = 3'b111
   } clk_sel_e;

   // Pin function codes
   localparam logic [1:0] FN_NONE   = 2'b00;
   localparam logic [1:0] FN_LOW    = 2'b01;
   localparam logic [1:0] FN_HIGH   = 2'b10;
   localparam logic [1:0] FN_TOGGLE = 2'b11;

   typedef struct packed {
      logic                 count_pause;
      clk_sel_e             clk_sel;
      logic                 module_on;
      logic [PER_W-1:0]     period_value;
   } timer_control_zero_s;

   typedef struct packed {
      op_mode_e             op_mode;
      logic [1:0]           pin_function;
      logic                 output_control;
      logic                 output_polarity;
      logic                 duty_period_swap;
      logic                 clear_select;
   } timer_control_one_s;

endpackage : standard_timer_pkg

// ==== tb_top.sv ====
// Self-checking testbench for the standard timer module
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import standard_timer_pkg::*;

   typedef struct {
      logic [7:0] c0;
      logic [7:0] c1;
      logic [9:0] ca;
      int         n;
      logic [3:0] exp;
   } row_s;

   logic       i_clk = 1'b0;
   logic       i_resetn = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic       i_wr = 1'b0;
   logic       i_rd = 1'b0;
   logic       i_fh_tick = 1'b0;
   logic       i_fsub_tick = 1'b0;
   logic       i_external_count_pin = 1'b0;
   logic       ext_en = 1'b0;
   logic [7:0] cyc = 8'h00;
   logic [7:0] o_rdata;
   logic       o_pin_out;
   logic       o_pin_oe_n;
   logic       o_compare_a_flag;
   logic       o_compare_p_flag;
   logic [7:0] v;
   logic [7:0] w;
   string      nm;
   int         error_cnt = 0;
   int         checked = 0;
   int         h;
   int         d;
   int         divs [8] = '{4, 1, 32, 128, 8, 8, 8, 8};
   // Outputs: {pin, pin enable low, P flag, A flag}
   row_s       rows [12] = '{
      '{8'h18, 8'h09, 10'h005, 6, 4'h9},
      '{8'h18, 8'h19, 10'h005, 6, 4'h1},
      '{8'h18, 8'h21, 10'h005, 6, 4'h9},
      '{8'h18, 8'h31, 10'h005, 6, 4'h9},
      '{8'h18, 8'h3D, 10'h005, 6, 4'h9},
      '{8'h18, 8'hF1, 10'h005, 6, 4'h5},
      '{8'h19, 8'h30, 10'h005, 129, 4'hB},
      '{8'h19, 8'h31, 10'h0C8, 210, 4'h9},
      '{8'h18, 8'h30, 10'h000, 1030, 4'h2},
      '{8'h19, 8'h88, 10'h005, 129, 4'h3},
      '{8'h19, 8'h98, 10'h005, 129, 4'hB},
      '{8'h19, 8'h9C, 10'h005, 129, 4'h3}};

   standard_timer_module standard_timer_module_i (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_fh_tick(i_fh_tick), .i_fsub_tick(i_fsub_tick),
      .i_external_count_pin(i_external_count_pin),
      .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
      .o_compare_a_flag(o_compare_a_flag),
      .o_compare_p_flag(o_compare_p_flag));

   always #5 i_clk = ~i_clk;

   // Clock sources: fH tick every 2, fSUB every 8, pin period 8
   always @(posedge i_clk) begin
      cyc <= cyc + 8'h01;
      i_fh_tick <= (cyc[0] == 1'b0);
      i_fsub_tick <= (cyc[2:0] == 3'h0);
      i_external_count_pin <= cyc[2] & ext_en;
   end

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] dat);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= dat;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] val);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 val = o_rdata;
   endtask : rd

   // Stop, clear flags, load settings, then switch on
   task automatic cfg(input logic [7:0] c0, c1, input logic [9:0] ca);
      wr(OFS_CTRL_ZERO, c0 & 8'hF7);
      wr(OFS_FLAGS, 8'h03);
      wr(OFS_CTRL_ONE, c1);
      wr(OFS_CMPA_LOW, ca[7:0]);
      wr(OFS_CMPA_HIGH, {6'h00, ca[9:8]});
      wr(OFS_CTRL_ZERO, c0);
   endtask : cfg

   task automatic high_time(input int n);
      h = 0;
      repeat (n) begin
         @(negedge i_clk);
         h += int'(o_pin_out);
      end
   endtask : high_time

   task automatic pwm(input logic [7:0] c0, c1, input logic [9:0] ca,
                      input int n, input int hi);
      cfg(c0, c1, ca);
      high_time(n);
      chk("high time", 8'(h >= hi - 3 && h <= hi + 3), 8'h01);
   endtask : pwm

   task automatic end_of_test;
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), v);
         chk("reset value", v, 8'h00);
      end
      wr(OFS_CMPA_LOW, 8'hA5);
      wr(OFS_CMPA_HIGH, 8'hFF);
      wr(OFS_CNT_LOW, 8'h55);
      wr(3'h7, 8'hFF);
      rd(OFS_CMPA_LOW, v);
      chk("compare low", v, 8'hA5);
      rd(OFS_CMPA_HIGH, v);
      chk("compare high", v, 8'h03);
      rd(OFS_CNT_LOW, v);
      chk("count read only", v, 8'h00);
      rd(3'h7, v);
      chk("unmapped", v, 8'h00);
      cfg(8'h18, 8'h00, 10'h000);
      rd(OFS_CNT_LOW, v);
      chk("count start", v, 8'h00);
      rd(OFS_CNT_LOW, w);
      chk("count run", w, 8'h02);
      wr(OFS_CTRL_ZERO, 8'h98);
      rd(OFS_CNT_LOW, v);
      rd(OFS_CNT_LOW, w);
      chk("count paused", w, v);
      wr(OFS_CTRL_ZERO, 8'h18);
      rd(OFS_CNT_LOW, w);
      chk("count resumed", w, v + 8'h01);
      wr(OFS_CTRL_ZERO, 8'h10);
      rd(OFS_CNT_LOW, v);
      repeat (5) @(posedge i_clk);
      rd(OFS_CNT_LOW, w);
      chk("count held", w, v);
      wr(OFS_CTRL_ZERO, 8'h18);
      rd(OFS_CNT_LOW, v);
      chk("count restart", v, 8'h00);
      repeat (300) @(posedge i_clk);
      rd(OFS_CNT_HIGH, v);
      chk("count high", v, 8'h01);
      foreach (rows[i]) begin
         cfg(rows[i].c0, rows[i].c1, rows[i].ca);
         repeat (rows[i].n) @(posedge i_clk);
         wr(OFS_CTRL_ZERO, rows[i].c0 & 8'hF7);
         repeat (2) @(posedge i_clk);
         #1 w = {4'h0, o_pin_out, o_pin_oe_n, o_compare_p_flag,
            o_compare_a_flag};
         nm = $sformatf("row %0d", i);
         chk(nm, w, {4'h0, rows[i].exp});
         rd(OFS_FLAGS, v);
         chk("flag register", v, {6'h00, rows[i].exp[1:0]});
      end
      ext_en <= 1'b1;
      for (int s = 0; s < 8; s++) begin
         if (s != 1) begin
            cfg({1'b0, 3'(s), 4'h8}, 8'h00, 10'h000);
            repeat (256) @(posedge i_clk);
            wr(OFS_CTRL_ZERO, 8'h00);
            rd(OFS_CNT_LOW, v);
            d = int'(v) - 256 / divs[s];
            chk("count rate", 8'(d >= -2 && d <= 2), 8'h01);
         end
      end
      ext_en <= 1'b0;
      pwm(8'h19, 8'hA8, 10'h020, 256, 64);
      pwm(8'h19, 8'hAC, 10'h020, 256, 192);
      pwm(8'h19, 8'hAA, 10'h200, 512, 128);
      pwm(8'h19, 8'hA8, 10'h0C8, 256, 256);
      pwm(8'h19, 8'hB8, 10'h014, 60, 20);
      rd(OFS_CTRL_ZERO, v);
      chk("pulse on cleared", v, 8'h11);
      rd(OFS_FLAGS, v);
      chk("pulse flag", v & 8'h01, 8'h01);
      cfg(8'h11, 8'hB8, 10'h014);
      ext_en <= 1'b1;
      high_time(16);
      d = h;
      ext_en <= 1'b0;
      high_time(60);
      chk("pin trigger", 8'(h + d >= 17 && h + d <= 23), 8'h01);
      rd(OFS_CTRL_ZERO, v);
      chk("trigger on cleared", v, 8'h11);
      cfg(8'h18, 8'h31, 10'h005);
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_clk);
      #1 w = {4'h0, o_pin_out, o_pin_oe_n, o_compare_p_flag,
         o_compare_a_flag};
      chk("reset outputs", w, 8'h04);
      @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(OFS_CTRL_ONE, v);
      chk("reset control", v, 8'h00);
      end_of_test();
   end

   initial begin
      #500_000;
      error_cnt++;
      end_of_test();
   end

endmodule : tb_top

`default_nettype wire
